//--- core/urt_pkg.sv
// Package for the receive timeout and FIFO trigger DMA request block
// Operation
// - Timeout period comes from the high and low timeout value registers combined.
// - Bit 6 of second enhanced feature register selects periodic (1) or original (0) mode.
// - Reading the interrupt identification register clears a pending timeout interrupt.
// - With unread receive data, timeout interrupt is raised again when timeout recurs.
// - Periodic mode raises the timeout interrupt anew at every period expiry.
// - Receive holding, modem status and line status reads leave the timeout interrupt alone.
package urt_pkg;
  localparam int unsigned TMO_HALF_W = 8;
  localparam int unsigned TMO_W = 2 * TMO_HALF_W;
  localparam int unsigned LVL_W = 6;
  localparam int unsigned FEAT_W = 8;
  localparam int unsigned FEAT_PERIODIC_BIT = 6;
  localparam logic [TMO_HALF_W-1:0] TMO_HIGH_RST = 8'h00;
  localparam logic [TMO_HALF_W-1:0] TMO_LOW_RST = 8'h40;
  localparam logic [FEAT_W-1:0] FEAT_RST = 8'h00;
  localparam logic [LVL_W-1:0] LVL_RST = 6'h01;

  typedef struct packed {
    logic rx_push;
    logic rx_pop;
    logic [LVL_W-1:0] rx_count;
    logic [LVL_W-1:0] tx_count;
  } urt_fifo_t;

  typedef struct packed {
    logic ident_read;
    logic hold_read;
    logic modem_read;
    logic line_read;
  } urt_reads_t;

  typedef enum logic [1:0] {
    TS_IDLE,
    TS_COUNT,
    TS_FIRED
  } urt_tstate_t;
endpackage : urt_pkg

//--- core/urt_rx_timeout.sv
// Receive timeout interrupt and FIFO trigger DMA request logic
module urt_rx_timeout (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [urt_pkg::TMO_HALF_W-1:0] rx_timeout_value_high,
  input wire logic [urt_pkg::TMO_HALF_W-1:0] rx_timeout_value_low,
  input wire logic tmo_wr,
  input wire logic [urt_pkg::FEAT_W-1:0] second_enhanced_feature_reg,
  input wire logic feat_wr,
  input wire logic [urt_pkg::LVL_W-1:0] rx_trig_level,
  input wire logic [urt_pkg::LVL_W-1:0] tx_trig_level,
  input wire logic trig_wr,
  input wire urt_pkg::urt_fifo_t fifo,
  input wire urt_pkg::urt_reads_t reads,
  output logic rx_timeout_irq,
  output logic periodic_mode,
  output logic rx_dma_req,
  output logic tx_dma_req,
  output logic [urt_pkg::TMO_W-1:0] tmo_count
);
  import urt_pkg::*;

  logic [TMO_W-1:0] period_q;
  logic [FEAT_W-1:0] feat_q;
  logic [LVL_W-1:0] rx_lvl_q;
  logic [LVL_W-1:0] tx_lvl_q;
  logic [TMO_W-1:0] cnt_q;
  logic irq_q;
  logic rx_dma_q;
  logic tx_dma_q;
  urt_tstate_t st_q;
  logic activity;
  logic pending;
  logic expire;

  assign activity = fifo.rx_push | fifo.rx_pop;
  // Data counted as pending from the push cycle, before the count shows it
  assign pending = (fifo.rx_count != '0) || fifo.rx_push;
  // A zero period is treated as one cycle so the timer can still fire
  assign expire = (st_q == TS_COUNT) && !activity &&
                  ((cnt_q + 16'h0001) >= period_q);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      period_q <= {TMO_HIGH_RST, TMO_LOW_RST};
    end else if (clk_en && tmo_wr) begin
      period_q <= {rx_timeout_value_high, rx_timeout_value_low};
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      feat_q <= FEAT_RST;
    end else if (clk_en && feat_wr) begin
      feat_q <= second_enhanced_feature_reg;
    end
  end

  assign periodic_mode = feat_q[FEAT_PERIODIC_BIT];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_lvl_q <= LVL_RST;
      tx_lvl_q <= LVL_RST;
    end else if (clk_en && trig_wr) begin
      // Non power-of-two levels are stored as written; DMA users must avoid them
      rx_lvl_q <= rx_trig_level;
      tx_lvl_q <= tx_trig_level;
    end
  end

  // Timer sequencer: original mode fires, then rearms on FIFO activity or once the interrupt is cleared with data pending; periodic mode keeps firing
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= TS_IDLE;
      cnt_q <= '0;
    end else if (clk_en) begin
      if (activity) begin
        st_q <= TS_COUNT;
        cnt_q <= '0;
      end else begin
        unique case (st_q)
          TS_IDLE: begin
            cnt_q <= '0;
            if (pending) begin
              st_q <= TS_COUNT;
            end
          end
          TS_COUNT: begin
            if (expire) begin
              cnt_q <= '0;
              st_q <= periodic_mode ? TS_COUNT : TS_FIRED;
            end else begin
              cnt_q <= cnt_q + 16'h0001;
            end
          end
          TS_FIRED: begin
            cnt_q <= '0;
            if (periodic_mode) begin
              st_q <= TS_COUNT;
            end else if (!irq_q && pending) begin
              st_q <= TS_COUNT;
            end
          end
        endcase
      end
    end
  end

  // Interrupt flag; expiry with data pending or in periodic mode wins over a same-cycle identification read
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else if (clk_en) begin
      if (expire && (pending || periodic_mode)) begin
        irq_q <= 1'b1;
      end else if (reads.ident_read) begin
        irq_q <= 1'b0;
      end
      // Holding, modem and line status reads deliberately not decoded here
    end
  end

  assign rx_timeout_irq = irq_q;
  assign tmo_count = cnt_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_dma_q <= 1'b0;
      tx_dma_q <= 1'b0;
    end else if (clk_en) begin
      rx_dma_q <= (fifo.rx_count >= rx_lvl_q) && (rx_lvl_q != '0);
      tx_dma_q <= (fifo.tx_count < tx_lvl_q);
    end
  end

  assign rx_dma_req = rx_dma_q;
  assign tx_dma_req = tx_dma_q;

  a_ident_clears: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && reads.ident_read && !expire) |=> !rx_timeout_irq)
    else $error("identification read did not clear timeout interrupt");
  a_status_reads_keep: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && !reads.ident_read && !expire) |=> $stable(rx_timeout_irq))
    else $error("timeout interrupt changed without cause");
  a_reads_no_set: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && (reads.hold_read || reads.modem_read || reads.line_read) &&
      !reads.ident_read && !expire && !rx_timeout_irq) |=> !rx_timeout_irq)
    else $error("status read raised timeout interrupt");
  a_reads_no_clear: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && (reads.hold_read || reads.modem_read || reads.line_read) &&
      !reads.ident_read && rx_timeout_irq) |=> rx_timeout_irq)
    else $error("status read cleared timeout interrupt");
  a_expire_sets: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && expire && pending) |=> rx_timeout_irq)
    else $error("expiry with pending data did not raise interrupt");
  a_periodic_fires: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && expire && periodic_mode) |=> rx_timeout_irq)
    else $error("periodic expiry did not raise interrupt");
  a_no_data_quiet: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && expire && !pending && !periodic_mode && !reads.ident_read) |=>
      $stable(rx_timeout_irq))
    else $error("original mode expiry without data changed interrupt");
  a_push_restarts: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && activity) |=> (tmo_count == '0 && st_q == TS_COUNT))
    else $error("FIFO activity did not restart timer");
  a_count_steps: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && st_q == TS_COUNT && !activity && !expire) |=>
      tmo_count == $past(tmo_count) + 16'h0001)
    else $error("timer did not advance by one");
  a_idle_waits: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && st_q == TS_IDLE && !pending && !activity) |=> st_q == TS_IDLE)
    else $error("timer started without pending data");
  a_periodic_rearm: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && expire && periodic_mode && !feat_wr) |=> st_q == TS_COUNT)
    else $error("periodic mode did not rearm timer");
  a_original_holds: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && expire && !periodic_mode && !feat_wr) |=> st_q == TS_FIRED)
    else $error("original mode rearmed after expiry");
  a_fired_waits: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && st_q == TS_FIRED && !periodic_mode && irq_q && !activity) |=>
      st_q == TS_FIRED)
    else $error("timer rearmed before interrupt was cleared");
  a_retrigger: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && st_q == TS_FIRED && !irq_q && pending && !activity) |=> st_q == TS_COUNT)
    else $error("pending data did not rearm timer");
  a_period_load: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && tmo_wr) |=> period_q ==
      {$past(rx_timeout_value_high), $past(rx_timeout_value_low)})
    else $error("timeout period not loaded");
  a_feature_load: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && feat_wr) |=> feat_q == $past(second_enhanced_feature_reg))
    else $error("feature register not loaded");
  a_level_load: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && trig_wr) |=>
      (rx_lvl_q == $past(rx_trig_level) && tx_lvl_q == $past(tx_trig_level)))
    else $error("trigger levels not loaded");

  // A low clock enable must leave every register untouched
  a_freeze_timer: assert property (@(posedge core_clk) disable iff (rst)
    !clk_en |=> ($stable(tmo_count) && $stable(st_q)))
    else $error("timer moved while clock enable low");
  a_freeze_outputs: assert property (@(posedge core_clk) disable iff (rst)
    !clk_en |=> ($stable(rx_timeout_irq) && $stable(rx_dma_req) &&
      $stable(tx_dma_req)))
    else $error("outputs changed while clock enable low");
  a_freeze_config: assert property (@(posedge core_clk) disable iff (rst)
    !clk_en |=> ($stable(period_q) && $stable(feat_q) && $stable(rx_lvl_q) &&
      $stable(tx_lvl_q)))
    else $error("configuration changed while clock enable low");

  // Requests follow the FIFO levels one cycle late; odd levels are not filtered
  a_rx_dma_high: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && rx_lvl_q != '0 && fifo.rx_count >= rx_lvl_q) |=>
      rx_dma_req)
    else $error("receive DMA request missing at trigger level");
  a_rx_dma_low: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && fifo.rx_count < rx_lvl_q) |=> !rx_dma_req)
    else $error("receive DMA request below trigger level");
  a_tx_dma_high: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && fifo.tx_count < tx_lvl_q) |=> tx_dma_req)
    else $error("transmit DMA request missing below trigger level");
  a_tx_dma_low: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && fifo.tx_count >= tx_lvl_q) |=> !tx_dma_req)
    else $error("transmit DMA request at or above trigger level");

  c_fire: cover property (@(posedge core_clk) disable iff (rst) $rose(rx_timeout_irq));
  c_clear: cover property (@(posedge core_clk) disable iff (rst) $fell(rx_timeout_irq));
  c_periodic: cover property (@(posedge core_clk) disable iff (rst)
    expire && periodic_mode && rx_timeout_irq);
  c_rx_dma: cover property (@(posedge core_clk) disable iff (rst) $rose(rx_dma_req));
  c_rearm: cover property (@(posedge core_clk) disable iff (rst)
    st_q == TS_FIRED ##1 st_q == TS_COUNT);
endmodule : urt_rx_timeout

//--- dv/urt_far_model.sv
// Far side model: remote transmitter fills the receive FIFO, DMA engine drains it
module urt_far_model (
  input wire logic core_clk,
  input wire logic send,
  input wire logic take,
  input wire logic [5:0] tx_fill,
  output urt_pkg::urt_fifo_t fifo
);
  timeunit 1ns;
  timeprecision 1ns;
  import urt_pkg::*;
  int fill = 0;
  // A pop of an empty FIFO is never presented to the block
  assign fifo = '{send, take && fill > 0, LVL_W'(fill), tx_fill};
  always @(posedge core_clk) begin
    fill <= fill + int'(send) - int'(take && fill > 0);
  end
endmodule : urt_far_model

//--- dv/test_urt_rx_timeout.sv
// Self-checking bench for the receive timeout and DMA request block
module test_urt_rx_timeout;
  timeunit 1ns;
  timeprecision 1ns;
  import urt_pkg::*;
  logic core_clk = 0, rst = 1, clk_en = 1, tmo_wr = 0, feat_wr = 0, trig_wr = 0;
  logic send = 0, take = 0, irq, per, rx_req, tx_req;
  logic [7:0] t_hi = 0, t_lo = 0, feat = 0;
  logic [5:0] rx_lvl = 1, tx_lvl = 1, tx_fill = 0;
  logic [15:0] tcount;
  urt_fifo_t fifo;
  urt_reads_t reads = '0;
  int bad_count = 0, comparisons = 0, cycles = 0, seed = 54330, p;
  int lv[6] = '{1, 2, 4, 8, 16, 32};
  byte rxq[$];
  always #10 core_clk = ~core_clk;
  urt_far_model far (.core_clk(core_clk), .send(send), .take(take), .tx_fill(tx_fill),
    .fifo(fifo));
  urt_rx_timeout uut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
    .rx_timeout_value_high(t_hi), .rx_timeout_value_low(t_lo), .tmo_wr(tmo_wr),
    .second_enhanced_feature_reg(feat), .feat_wr(feat_wr), .rx_trig_level(rx_lvl),
    .tx_trig_level(tx_lvl), .trig_wr(trig_wr), .fifo(fifo), .reads(reads),
    .rx_timeout_irq(irq), .periodic_mode(per), .rx_dma_req(rx_req), .tx_dma_req(tx_req),
    .tmo_count(tcount));
  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %b expected %b", $time, got, exp);
    end
  endtask : chk
  task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: timer %h expected %h", $time, got, exp);
    end
  endtask : chk_cnt
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick
  // k: 0 interrupt id, 1 holding, 2 modem status, 3 line status
  task automatic rd(input int k);
    reads = 4'(4'h8 >> k);
    tick(1);
    reads = '0;
    // Idle cycle keeps back-to-back strobes apart
    tick(1);
  endtask : rd
  task automatic push_char();
    rxq.push_back(8'($random(seed)));
    send = 1;
    tick(1);
    send = 0;
    tick(1);
  endtask : push_char
  task automatic set_period(input logic [7:0] hi, input logic [7:0] lo);
    t_hi = hi;
    t_lo = lo;
    tmo_wr = 1;
    tick(1);
    tmo_wr = 0;
  endtask : set_period
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    tick(5);
    rst = 0;
    chk(irq, 1'b0);
    chk_cnt(tcount, 16'h0000);
    p = 5 + int'($unsigned($random(seed)) % 6);
    set_period(8'h00, 8'(p));
    push_char();
    tick(p - 2);
    chk_cnt(tcount, 16'(p - 1));
    chk(irq, 1'b0);
    // Expiry is due on the next edge; a low enable must hold it off
    clk_en = 0;
    tick(3);
    chk_cnt(tcount, 16'(p - 1));
    chk(irq, 1'b0);
    clk_en = 1;
    tick(2);
    chk(irq, rxq.size() > 0);
    for (int k = 1; k < 4; k++) begin
      rd(k);
      chk(irq, 1'b1);
    end
    rd(0);
    chk(irq, 1'b0);
    tick(p + 3);
    chk(irq, rxq.size() > 0);
    take = 1;
    tick(1);
    take = 0;
    void'(rxq.pop_front());
    rd(0);
    tick(2 * p + 4);
    chk(irq, 1'b0);
    for (int k = 1; k < 4; k++) begin
      rd(k);
      chk(irq, 1'b0);
    end
    // Long period keeps expiries far from the clearing reads
    set_period(8'h01, 8'h00);
    feat = 8'h40;
    feat_wr = 1;
    tick(1);
    feat_wr = 0;
    chk(per, 1'b1);
    push_char();
    tick(250);
    chk(irq, 1'b0);
    tick(10);
    chk(irq, 1'b1);
    take = 1;
    tick(1);
    take = 0;
    void'(rxq.pop_front());
    rd(0);
    chk(irq, 1'b0);
    tick(250);
    chk(irq, 1'b0);
    tick(10);
    chk(irq, 1'b1);
    feat = 8'h00;
    feat_wr = 1;
    tick(1);
    feat_wr = 0;
    chk(per, 1'b0);
    foreach (lv[i]) begin
      rx_lvl = 6'(lv[i]);
      tx_lvl = 6'(lv[i]);
      trig_wr = 1;
      tick(1);
      trig_wr = 0;
      while (rxq.size() < lv[i] - 1) push_char();
      tx_fill = 6'(lv[i] - 1);
      tick(2);
      chk(rx_req, rxq.size() >= lv[i]);
      chk(tx_req, 1'b1);
      push_char();
      tx_fill = 6'(lv[i]);
      tick(2);
      chk(rx_req, rxq.size() >= lv[i]);
      chk(tx_req, 1'b0);
    end
    report_and_stop();
  end
endmodule : test_urt_rx_timeout
